/* File: hw/acmc_pkg.sv */
// Package for the converter multiplexer and conversion control block.
// Assumes a 32-bit APB slave with an 8-bit byte address.
package acmc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ACMC_OFF_INPUT_SEL = 8'h00;
  localparam logic [7:0] ACMC_OFF_CTRL_STS  = 8'h04;
  localparam logic [7:0] ACMC_OFF_RES_LOW   = 8'h08;
  localparam logic [7:0] ACMC_OFF_RES_HIGH  = 8'h0C;
  localparam logic [7:0] ACMC_OFF_SFIO      = 8'h10;
  localparam logic [7:0] ACMC_OFF_EVT_STS   = 8'h14;
  localparam logic [7:0] ACMC_OFF_EVT_MASK  = 8'h18;

  // ==========================================================
  // Field positions
  localparam int ACMC_IS_REF_LSB   = 6;
  localparam int ACMC_IS_LJUST     = 5;
  localparam int ACMC_CS_ENABLE    = 7;
  localparam int ACMC_CS_START     = 6;
  localparam int ACMC_CS_AUTO_TRIG = 5;
  localparam int ACMC_CS_DONE_FLAG = 4;
  localparam int ACMC_CS_DONE_IE   = 3;
  localparam int ACMC_SF_TSEL_LSB  = 5;
  localparam int ACMC_EVT_DONE     = 0;
  localparam int ACMC_EVT_ABORT    = 1;

  // ==========================================================
  // Reset values and codes
  localparam logic [7:0]  ACMC_RST_BYTE      = 8'h00;
  localparam logic [1:0]  ACMC_REF_EXT       = 2'b00;
  localparam logic [1:0]  ACMC_REF_SUPPLY    = 2'b01;
  localparam logic [1:0]  ACMC_REF_INT       = 2'b11;
  localparam logic [4:0]  ACMC_MUX_BANDGAP   = 5'b11110;
  localparam logic [4:0]  ACMC_MUX_GROUND    = 5'b11111;
  localparam logic [2:0]  ACMC_TSEL_FREE_RUN = 3'b000;
  localparam logic [1:0]  ACMC_GAIN_1X       = 2'd0;
  localparam logic [1:0]  ACMC_GAIN_10X      = 2'd1;
  localparam logic [1:0]  ACMC_GAIN_200X     = 2'd2;

  // ==========================================================
  // Timing counts in converter clock cycles
  localparam logic [4:0] ACMC_CONV_FIRST_TICKS = 5'd25;
  localparam logic [4:0] ACMC_CONV_NORM_TICKS  = 5'd13;
  localparam logic [7:0] ACMC_DIV_MIN          = 8'd2;

  // Analog front end steering
  typedef struct packed {
    logic [1:0] ref_sel;
    logic       int_ref_on;
    logic       single_ended;
    logic       differential;
    logic [2:0] pos_in;
    logic [2:0] neg_in;
    logic [1:0] gain;
    logic       bandgap;
    logic       ground;
  } acmc_ana_t;

endpackage

/* File: hw/acmc_ctrl.sv */
// Converter multiplexer selection and conversion control, APB slave.
// Assumes the converter result is stable on i_sar_result at conversion end
// and the trigger inputs are asynchronous level flags.
//
// What this block does
// - Reference code picks external, supply or internal
// - Selection changes apply only when idle, never between back-to-back conversions
// - Left justify alters presented data immediately
// - Codes 0-7 single, bandgap, ground
// - Decode differential gain and unity pairs
// - Enable powers up; disable aborts conversion
// - Start begins one, or first free run
// - First conversion 25 ticks, others 13
// - Start reads busy; writing zero ignored
// - Auto trigger on selected source rising edge
// - Done flag set in the result update cycle
// - Done flag cleared by vector or one
// - Interrupt when flag, enable, global set
// - Prescaler divides by 2 to 128
// - Low byte read locks result until high
// - Trigger source decode; free run never triggers
// - Differential results in two's complement
module acmc_ctrl
  import acmc_pkg::*;
#(
  parameter int TRIG_SRCS = 7
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // APB slave
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [7:0]           i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic      [31:0]          o_prdata,
  output logic                      o_pready,
  output logic                      o_pslverr,
  // Processor side
  input  wire logic                 i_global_irq_en,
  input  wire logic                 i_irq_vector_ack,
  output logic                      o_irq,
  // Trigger sources 1..7
  input  wire logic [TRIG_SRCS-1:0] i_trig_src,
  // Converter side
  input  wire logic [9:0]           i_sar_result,
  output acmc_ana_t                 o_ana_sel,
  output logic                      o_powered,
  output logic                      o_busy,
  output logic                      o_sample,
  output logic                      o_conv_tick
);

  // ==========================================================
  // Functions
  function automatic acmc_ana_t decode_sel(input logic [1:0] ref_sel,
                                           input logic [4:0] mux);
    acmc_ana_t a;
    a = '0;
    a.ref_sel    = ref_sel;
    a.int_ref_on = (ref_sel == ACMC_REF_INT);
    if (mux[4:3] == 2'b00) begin
      a.single_ended = 1'b1;
      a.pos_in       = mux[2:0];
    end else if (mux == ACMC_MUX_BANDGAP) begin
      a.bandgap = 1'b1;
    end else if (mux == ACMC_MUX_GROUND) begin
      a.ground = 1'b1;
    // gain pairs against input 0 or 2
    end else if (mux[4:3] == 2'b01) begin
      a.differential = 1'b1;
      a.pos_in       = {1'b0, mux[2], mux[0]};
      a.neg_in       = mux[2] ? 3'd2 : 3'd0;
      a.gain         = mux[1] ? ACMC_GAIN_200X : ACMC_GAIN_10X;
    // unity pairs against input 1 or 2
    end else begin
      a.differential = 1'b1;
      a.pos_in       = mux[2:0];
      a.neg_in       = mux[3] ? 3'd2 : 3'd1;
      a.gain         = ACMC_GAIN_1X;
    end
    return a;
  endfunction

  function automatic logic [7:0] div_factor(input logic [2:0] sel);
    if (sel < 3'd2) begin
      return ACMC_DIV_MIN;
    end
    return 8'h01 << sel;
  endfunction

  // ==========================================================
  // Registers
  logic [1:0]           ref_r;
  logic                 ljust_r;
  logic [4:0]           mux_r;
  logic                 en_r;
  logic                 ate_r;
  logic                 flag_r;
  logic                 ie_r;
  logic [2:0]           div_r;
  logic [2:0]           tsel_r;
  logic [1:0]           evt_sts_r;
  logic [1:0]           evt_mask_r;
  logic                 busy_r;
  logic                 first_pend_r;
  logic [4:0]           conv_len_r;
  logic [4:0]           tick_cnt_r;
  logic [6:0]           pre_cnt_r;
  acmc_ana_t            act_r;
  logic [9:0]           result_r;
  logic                 lock_r;
  logic [31:0]          prdata_r;
  logic                 err_r;
  logic [TRIG_SRCS-1:0] trig_s1_r;
  logic [TRIG_SRCS-1:0] trig_s2_r;
  logic                 trig_prev_r;

  // ==========================================================
  // APB decode
  logic        wr_acc;
  logic        rd_acc;
  logic        rd_setup;
  logic        addr_ok;
  logic        wr_is;
  logic        wr_cs;
  logic        en_nxt;
  logic [15:0] present;

  assign wr_acc   = i_psel && i_penable && i_pwrite;
  assign rd_acc   = i_psel && i_penable && !i_pwrite;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign addr_ok  = (i_paddr == ACMC_OFF_INPUT_SEL) || (i_paddr == ACMC_OFF_CTRL_STS) ||
                    (i_paddr == ACMC_OFF_RES_LOW)   || (i_paddr == ACMC_OFF_RES_HIGH) ||
                    (i_paddr == ACMC_OFF_SFIO)      || (i_paddr == ACMC_OFF_EVT_STS)  ||
                    (i_paddr == ACMC_OFF_EVT_MASK);
  assign wr_is    = wr_acc && (i_paddr == ACMC_OFF_INPUT_SEL);
  assign wr_cs    = wr_acc && (i_paddr == ACMC_OFF_CTRL_STS);
  assign en_nxt   = wr_cs ? i_pwdata[ACMC_CS_ENABLE] : en_r;

  // presentation follows the live justify bit
  assign present  = ljust_r ? {result_r, 6'b00_0000} : {6'b00_0000, result_r};

  assign o_pready  = 1'b1;
  assign o_prdata  = prdata_r;
  assign o_pslverr = i_psel && i_penable && err_r;

  // ==========================================================
  // Trigger synchroniser and edge detect
  logic trig_sel;
  logic trig_rise;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      trig_s1_r   <= '0;
      trig_s2_r   <= '0;
      trig_prev_r <= 1'b0;
    end else begin
      trig_s1_r   <= i_trig_src;
      trig_s2_r   <= trig_s1_r;
      trig_prev_r <= trig_sel;
    end
  end

  // free run selects no external source
  assign trig_sel  = (tsel_r == ACMC_TSEL_FREE_RUN) ? 1'b0 : trig_s2_r[tsel_r - 3'd1];
  assign trig_rise = trig_sel && !trig_prev_r;

  // ==========================================================
  // Prescaler
  logic [7:0] div_val;
  logic       tick;

  assign div_val = div_factor(div_r);
  assign tick    = en_r && ({1'b0, pre_cnt_r} >= (div_val - 8'd1));

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pre_cnt_r <= '0;
    end else if (!en_r || tick) begin
      pre_cnt_r <= '0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 7'd1;
    end
  end

  // ==========================================================
  // Conversion sequencer
  logic sw_start;
  logic auto_start;
  logic free_start;
  logic start_req;
  logic first_now;
  logic done_pulse;
  logic abort;

  // a start write begins one conversion
  assign sw_start   = wr_cs && i_pwdata[ACMC_CS_START];
  assign auto_start = en_r && ate_r && trig_rise;
  assign free_start = ate_r && (tsel_r == ACMC_TSEL_FREE_RUN) && done_pulse;
  assign start_req  = (sw_start || auto_start || free_start) && en_nxt &&
                      (!busy_r || done_pulse);
  assign first_now  = first_pend_r || (en_nxt && !en_r);
  assign done_pulse = busy_r && tick && (tick_cnt_r == conv_len_r - 5'd1) && en_nxt;
  assign abort      = busy_r && !en_nxt;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_r     <= 1'b0;
      tick_cnt_r <= '0;
      conv_len_r <= ACMC_CONV_NORM_TICKS;
    end else if (start_req) begin
      busy_r     <= 1'b1;
      tick_cnt_r <= '0;
      conv_len_r <= first_now ? ACMC_CONV_FIRST_TICKS : ACMC_CONV_NORM_TICKS;
    end else if (abort || done_pulse) begin
      busy_r     <= 1'b0;
      tick_cnt_r <= '0;
    end else if (busy_r && tick) begin
      tick_cnt_r <= tick_cnt_r + 5'd1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      first_pend_r <= 1'b0;
    end else if (start_req) begin
      first_pend_r <= 1'b0;
    end else if (en_nxt && !en_r) begin
      first_pend_r <= 1'b1;
    end
  end

  // selection held for the whole conversion
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      act_r <= '0;
    end else if (!busy_r) begin
      act_r <= decode_sel(ref_r, mux_r);
    end
  end

  assign o_ana_sel   = act_r;
  assign o_powered   = en_r;
  assign o_busy      = busy_r;
  assign o_sample    = busy_r && (tick_cnt_r == 5'd0) && tick;
  assign o_conv_tick = busy_r && tick;

  // ==========================================================
  // Result and read lock
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      result_r <= '0;
    // locked result keeps the old value
    end else if (done_pulse && !lock_r) begin
      result_r <= act_r.differential ? {~i_sar_result[9], i_sar_result[8:0]} : i_sar_result;
    end
  end

  // low byte read locks, high byte unlocks
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lock_r <= 1'b0;
    end else if (rd_acc && (i_paddr == ACMC_OFF_RES_LOW)) begin
      lock_r <= 1'b1;
    end else if (rd_acc && (i_paddr == ACMC_OFF_RES_HIGH)) begin
      lock_r <= 1'b0;
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ref_r   <= '0;
      ljust_r <= 1'b0;
      mux_r   <= '0;
    end else if (wr_is) begin
      ref_r   <= i_pwdata[ACMC_IS_REF_LSB +: 2];
      ljust_r <= i_pwdata[ACMC_IS_LJUST];
      mux_r   <= i_pwdata[4:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      en_r   <= 1'b0;
      ate_r  <= 1'b0;
      ie_r   <= 1'b0;
      div_r  <= '0;
      tsel_r <= '0;
    end else begin
      en_r <= en_nxt;
      if (wr_cs) begin
        ate_r <= i_pwdata[ACMC_CS_AUTO_TRIG];
        ie_r  <= i_pwdata[ACMC_CS_DONE_IE];
        div_r <= i_pwdata[2:0];
      end
      if (wr_acc && (i_paddr == ACMC_OFF_SFIO)) begin
        tsel_r <= i_pwdata[ACMC_SF_TSEL_LSB +: 3];
      end
    end
  end

  // flag set on completion, set wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flag_r <= 1'b0;
    end else if (done_pulse) begin
      flag_r <= 1'b1;
    // vector or write of one clears
    end else if (i_irq_vector_ack || (wr_cs && i_pwdata[ACMC_CS_DONE_FLAG])) begin
      flag_r <= 1'b0;
    end
  end

  // Event status, write one to clear, set wins
  logic [1:0] evt_set;
  logic [1:0] evt_clr;

  assign evt_set = {abort, done_pulse};
  assign evt_clr = (wr_acc && (i_paddr == ACMC_OFF_EVT_STS)) ? i_pwdata[1:0] : 2'b00;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      evt_sts_r  <= '0;
      evt_mask_r <= '0;
    end else begin
      evt_sts_r <= (evt_sts_r & ~evt_clr) | evt_set;
      if (wr_acc && (i_paddr == ACMC_OFF_EVT_MASK)) begin
        evt_mask_r <= i_pwdata[1:0];
      end
    end
  end

  // flag gated by enable, events by mask, both by global enable
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= i_global_irq_en && ((flag_r && ie_r) || |(evt_sts_r & evt_mask_r));
    end
  end

  // ==========================================================
  // Read data captured in the setup cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prdata_r <= '0;
      err_r    <= 1'b0;
    end else if (i_psel && !i_penable) begin
      err_r    <= !addr_ok;
      prdata_r <= '0;
      if (rd_setup) begin
        case (i_paddr)
          ACMC_OFF_INPUT_SEL: prdata_r[7:0] <= {ref_r, ljust_r, mux_r};
          ACMC_OFF_CTRL_STS:  prdata_r[7:0] <= {en_r, busy_r, ate_r, flag_r, ie_r, div_r};
          ACMC_OFF_RES_LOW:   prdata_r[7:0] <= present[7:0];
          ACMC_OFF_RES_HIGH:  prdata_r[7:0] <= present[15:8];
          ACMC_OFF_SFIO:      prdata_r[7:0] <= {tsel_r, 5'b0_0000};
          ACMC_OFF_EVT_STS:   prdata_r[1:0] <= evt_sts_r;
          ACMC_OFF_EVT_MASK:  prdata_r[1:0] <= evt_mask_r;
          default:            prdata_r      <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_first_len;
    (start_req && first_now) |=> (conv_len_r == ACMC_CONV_FIRST_TICKS) && busy_r;
  endproperty
  a_first_len: assert property (p_first_len) else $error("first length wrong");

  property p_norm_len;
    (start_req && !first_now) |=> (conv_len_r == ACMC_CONV_NORM_TICKS);
  endproperty
  a_norm_len: assert property (p_norm_len) else $error("normal length wrong");

  property p_abort;
    (wr_cs && !i_pwdata[ACMC_CS_ENABLE]) |=> !busy_r && !o_powered;
  endproperty
  a_abort: assert property (p_abort) else $error("disable did not abort");

  property p_start_read;
    (rd_setup && (i_paddr == ACMC_OFF_CTRL_STS)) |=> (prdata_r[ACMC_CS_START] == $past(busy_r));
  endproperty
  a_start_read: assert property (p_start_read) else $error("start bit not busy");

  property p_done_flag;
    done_pulse |=> flag_r ##1 (flag_r || $past(i_irq_vector_ack) || $past(wr_cs));
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("flag not set");

  property p_zero_keeps;
    (flag_r && wr_cs && !i_pwdata[ACMC_CS_DONE_FLAG] && !i_irq_vector_ack) |=> flag_r;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

  property p_irq;
    (flag_r && ie_r && i_global_irq_en) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_sel_held;
    (busy_r && $past(busy_r)) |-> $stable(act_r);
  endproperty
  a_sel_held: assert property (p_sel_held) else $error("selection changed mid run");

  property p_lock;
    (lock_r && done_pulse) |=> $stable(result_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked result updated");

  property p_tick_gap;
    (tick && div_r == 3'd2 && !wr_cs) |=> !tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("prescaler gap wrong");

  property p_free_no_trig;
    ((tsel_r == ACMC_TSEL_FREE_RUN) && !busy_r && !sw_start) |=> !busy_r;
  endproperty
  a_free_no_trig: assert property (p_free_no_trig) else $error("free run triggered");

endmodule

/* File: test/acmc_sar_model.sv */
// Stand-in for the analog mux, gain stage and SAR converter.
// Assumes o_sample marks the first tick of each conversion.
module acmc_sar_model
  import acmc_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // From the control block
  input  wire acmc_ana_t  i_ana_sel,
  input  wire logic       i_sample,
  input  wire logic       i_busy,
  // Result back
  output logic      [9:0] o_result
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [9:0] held_r;

  // ==========================================================
  // Code taken from the selection at sample time
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      held_r <= 10'h000;
    end else if (i_sample) begin
      held_r <= {i_ana_sel.pos_in, i_ana_sel.differential, 6'h2D};
    end
  end

  // No valid code outside a conversion
  assign o_result = i_busy ? held_r : ~held_r;
endmodule

/* File: test/acmc_ctrl_bench.sv */
// Self-checking bench for the converter control block.
// Assumes the SAR stand-in on the far side and APB software access.
module acmc_ctrl_bench
  import acmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        gie = 1'b0;
  logic        ack = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [6:0]  trig = 7'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        powered;
  logic        busy;
  logic        sample;
  logic        tick;
  logic [9:0]  sar;
  acmc_ana_t   ana;
  logic [31:0] rdv;
  logic        erv;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  acmc_ctrl #(.TRIG_SRCS(7)) dut (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_global_irq_en(gie),
    .i_irq_vector_ack(ack), .o_irq(irq), .i_trig_src(trig), .i_sar_result(sar),
    .o_ana_sel(ana), .o_powered(powered), .o_busy(busy), .o_sample(sample),
    .o_conv_tick(tick)
  );

  acmc_sar_model sar_far (
    .i_ref_clk(clk), .i_rst(rst), .i_ana_sel(ana), .i_sample(sample),
    .i_busy(busy), .o_result(sar)
  );

  // ==========================================================
  // Reporting
  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Bus and wait helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic conv(output int ticks);
    ticks = 0;
    while (busy !== 1'b1) @(posedge clk);
    while (busy === 1'b1) begin
      if (tick === 1'b1) ticks++;
      @(posedge clk);
    end
  endtask

  task automatic samples(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      if (sample === 1'b1) cnt++;
    end
  endtask

  function automatic logic [9:0] raw(input logic [2:0] pos, input logic dif);
    raw = {pos, dif, 6'h2D};
    if (dif) raw[9] = ~raw[9];
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4));
      chk("reset value", 32'h0000_0000, rdv);
      chk("mapped error", 0, erv);
      chk("ready", 1, pready);
    end
    rd(8'h1C);
    chk("unmapped error", 1, erv);
    chk("unmapped data", 32'h0000_0000, rdv);
    wr(ACMC_OFF_CTRL_STS, 8'h40);
    rd(ACMC_OFF_CTRL_STS);
    chk("start while off", 32'h0000_0000, rdv); // ignored start
  endtask

  task automatic t_first_conv();
    int n;
    wr(ACMC_OFF_INPUT_SEL, 8'h03);
    wr(ACMC_OFF_CTRL_STS, 8'hC0);
    conv(n);
    chk("first length", 25, n); // first length
    rd(ACMC_OFF_CTRL_STS);
    chk("ctrl after", 32'h0000_0090, rdv); // enable and flag
    rd(ACMC_OFF_RES_LOW);
    chk("low byte", raw(3'd3, 1'b0) & 10'h0FF, rdv); // right layout
    rd(ACMC_OFF_RES_HIGH);
    chk("high byte", raw(3'd3, 1'b0) >> 8, rdv); // right layout
    wr(ACMC_OFF_CTRL_STS, 8'h90);
    rd(ACMC_OFF_CTRL_STS);
    chk("flag cleared", 32'h0000_0080, rdv); // write one
    wr(ACMC_OFF_CTRL_STS, 8'hC0);
    conv(n);
    chk("normal length", 13, n); // normal length
    wr(ACMC_OFF_CTRL_STS, 8'hC0);
    wr(ACMC_OFF_CTRL_STS, 8'h80);
    rd(ACMC_OFF_CTRL_STS);
    chk("start busy", 1, rdv[6]); // zero ignored
    conv(n);
    wr(ACMC_OFF_CTRL_STS, 8'h90);
  endtask

  task automatic t_lock();
    int n;
    rd(ACMC_OFF_RES_LOW);
    wr(ACMC_OFF_INPUT_SEL, 8'h0D);
    wr(ACMC_OFF_CTRL_STS, 8'hC0);
    conv(n);
    rd(ACMC_OFF_RES_HIGH);
    chk("locked high", raw(3'd3, 1'b0) >> 8, rdv); // held result
    rd(ACMC_OFF_RES_LOW);
    chk("locked low", raw(3'd3, 1'b0) & 10'h0FF, rdv); // held result
    rd(ACMC_OFF_RES_HIGH);
  endtask

  task automatic t_sel_hold();
    int n;
    wr(ACMC_OFF_CTRL_STS, 8'hD0);
    wr(ACMC_OFF_INPUT_SEL, 8'hE1);
    chk("pos held", 3, ana.pos_in); // channel held
    chk("ref held", 0, ana.ref_sel); // reference held
    rd(ACMC_OFF_RES_HIGH);
    chk("left now", raw(3'd3, 1'b0) >> 2, rdv); // immediate effect
    conv(n);
    repeat (2) @(posedge clk);
    chk("pos applied", 1, ana.pos_in); // applied after
    chk("ref applied", 3, ana.ref_sel); // applied after
    rd(ACMC_OFF_RES_LOW);
    chk("diff low", {raw(3'd3, 1'b1), 6'h00} & 16'h00FF, rdv); // signed result
    rd(ACMC_OFF_RES_HIGH);
    chk("diff high", raw(3'd3, 1'b1) >> 2, rdv); // signed result
    wr(ACMC_OFF_INPUT_SEL, 8'h03);
    wr(ACMC_OFF_CTRL_STS, 8'h90);
  endtask

  task automatic t_irq();
    int n;
    gie <= 1'b1;
    wr(ACMC_OFF_CTRL_STS, 8'hC8);
    conv(n);
    repeat (2) @(posedge clk);
    chk("irq set", 1, irq); // all enables
    wr(ACMC_OFF_CTRL_STS, 8'h88);
    repeat (2) @(posedge clk);
    chk("irq kept", 1, irq); // zero write
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq global off", 0, irq); // global gate
    gie <= 1'b1;
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq after ack", 0, irq); // vector clears
    wr(ACMC_OFF_EVT_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk("event irq", 1, irq);
    wr(ACMC_OFF_EVT_STS, 8'h03);
    repeat (2) @(posedge clk);
    chk("event cleared", 0, irq);
    wr(ACMC_OFF_EVT_MASK, 8'h00);
    wr(ACMC_OFF_CTRL_STS, 8'h80);
  endtask

  task automatic t_abort();
    int n;
    wr(ACMC_OFF_CTRL_STS, 8'hC0);
    repeat (6) @(posedge clk);
    wr(ACMC_OFF_CTRL_STS, 8'h00);
    repeat (2) @(posedge clk);
    chk("busy off", 0, busy); // abort
    chk("power off", 0, powered); // power down
    rd(ACMC_OFF_CTRL_STS);
    chk("no flag", 32'h0000_0000, rdv); // abort
    wr(ACMC_OFF_CTRL_STS, 8'hC0);
    conv(n);
    chk("re-enable length", 25, n); // first after enable
  endtask

  task automatic t_presc();
    int g;
    for (int c = 0; c < 8; c++) begin
      wr(ACMC_OFF_CTRL_STS, 8'hC0 | 8'(c));
      while (tick !== 1'b1) @(posedge clk);
      @(posedge clk);
      g = 1;
      while (tick !== 1'b1) begin
        @(posedge clk);
        g++;
      end
      chk("divider", (c < 2) ? 2 : (1 << c), g); // division factor
      wr(ACMC_OFF_CTRL_STS, 8'h00);
    end
  endtask

  task automatic t_trig();
    int n;
    wr(ACMC_OFF_SFIO, 8'h20);
    wr(ACMC_OFF_CTRL_STS, 8'hA0);
    samples(6, n);
    chk("no early start", 0, n); // trigger still low
    trig[0] <= 1'b1;
    samples(12, n);
    chk("trig start", 1, n); // rising edge
    conv(n);
    wr(ACMC_OFF_SFIO, 8'h00);
    samples(60, n);
    chk("free select quiet", 0, n); // no own trigger
    trig[0] <= 1'b0;
    wr(ACMC_OFF_CTRL_STS, 8'hF0);
    samples(100, n);
    chk("free running", 1, n >= 3); // automatic restarts
    wr(ACMC_OFF_CTRL_STS, 8'h00);
  endtask

  task automatic t_decode();
    acmc_ana_t e;
    acmc_ana_t m;
    logic [4:0] c;
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      wr(ACMC_OFF_INPUT_SEL, {c[1:0], 1'b0, c});
      repeat (2) @(posedge clk);
      e = '0;
      m = '1;
      e.ref_sel = c[1:0];
      e.int_ref_on = (c[1:0] == ACMC_REF_INT);
      e.differential = (i >= 8 && i < 30);
      e.single_ended = (i < 8);
      e.bandgap = (c == ACMC_MUX_BANDGAP);
      e.ground = (c == ACMC_MUX_GROUND);
      if (i < 16) begin
        e.pos_in = (i < 8) ? c[2:0] : {1'b0, c[2], c[0]};
        e.neg_in = c[2] ? 3'd2 : 3'd0;
        e.gain = c[1] ? ACMC_GAIN_200X : ACMC_GAIN_10X;
      end else begin
        e.pos_in = c[2:0];
        e.neg_in = c[3] ? 3'd2 : 3'd1;
        e.gain = ACMC_GAIN_1X;
      end
      if (i < 8 || i >= 30) begin
        m.neg_in = '0;
        m.gain = '0;
      end
      if (i >= 30) begin
        m.pos_in = '0;
        m.single_ended = 1'b0;
      end
      chk("selection", e & m, ana & m); // decode
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_first_conv();
    t_lock();
    t_sel_hold();
    t_irq();
    t_abort();
    t_presc();
    t_trig();
    t_decode();
    tally_and_finish();
  end
endmodule
